//--- rtl/setpoint_relay_regs.vh
// constants for the two-channel setpoint relay controller
`ifndef SETPOINT_RELAY_REGS_VH
`define SETPOINT_RELAY_REGS_VH

// ----------------------------------------------------------------
// apb register map
// ----------------------------------------------------------------
`define ADDR_W          12
`define ADDR_STATUS     12'h000
`define ADDR_SP_ONE     12'h004
`define ADDR_SP_TWO     12'h008
`define ADDR_PRESSURE   12'h00C

// ----------------------------------------------------------------
// setpoint word layout: mantissa 10..99, exponent code = exponent + 12
// ----------------------------------------------------------------
`define MAN_W           7
`define EXP_W           5
`define KEY_W           12
`define FLD_MAN         6:0
`define FLD_EXP         12:8
`define MAN_MIN         7'h0A
`define MAN_MAX         7'h63
`define MAN_TOP         7'h5A
`define MAN_TEN         7'h0A
`define MAN_HALF        7'h05
`define MAN_ONE         7'h01
`define EXP_MIN         5'h00
`define EXP_MAX         5'h11
`define EXP_ONE         5'h01
`define SP_RST_MAN      7'h0A
`define SP_RST_EXP      5'h06
`define KEY_ZERO        12'h000

// ----------------------------------------------------------------
// status word bits
// ----------------------------------------------------------------
`define ST_RELAY        1:0
`define ST_SHOWING      4
`define ST_PRESS_SEEN   5
`define ST_DEGAS        6
`define ST_GAUGE_ON     7
`define ST_ADJUSTED     8

// ----------------------------------------------------------------
// switch encodings
// ----------------------------------------------------------------
`define OVR_FORCE_ON    2'b01
`define OVR_FORCE_OFF   2'b10
`define DIS_BOTH_ON     2'b11

// ----------------------------------------------------------------
// timing at 100 MHz
// ----------------------------------------------------------------
`define CYC_PER_MS      100000
`define SHOW_MS         2000
`define SLOW_STEP_MS    400
`define FAST_STEP_MS    50
`define CNT_W           28
`define CNT_ONE         28'h0000001
`define CNT_ZERO        28'h0000000

`endif

//--- rtl/setpoint_relay_control.v
// two-channel setpoint comparator driving process relays, with apb access
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_relay_regs.vh"

// Functional notes
// R1: setpoints hold two mantissa digits and exponent, 1e-12 up to 9e5.
// R2: per-channel polarity switch; off activates below setpoint, on activates above.
// R3: below polarity: on at setpoint minus one digit, off at setpoint+10%+one digit.
// R4: hysteresis is one digit; second digit five or more rounds up, else truncates.
// R5: gauge off forces both process relays inactive.
// R6: during degas relays hold; comparison uses pressure frozen at degas start.
// R7: disable pair both on holds relay off; both off lets comparison drive it.
// R8: override right forces on, left forces off, centre automatic; beats comparison.
// R9: brief press of either button shows selected setpoint for two seconds.
// R10: channel selector chooses which setpoint is shown or adjusted.
// R11: held button steps setpoint; slow until decade crossed, then fast.
// R12: two seconds after release, display returns and an adjusted setpoint goes to storage.
// R13: setpoints compare directly to display value, no unit conversion.
// R14: while setpoint is displayed, pressure updates are ignored; last value kept.
// R15: status leds show actual relay state, including overrides.
// R16: working copies of both setpoints kept internally for comparison.
// R17: priority: disable, then gauge-off and degas hold, then override, then compare.
// R18: scrolling clamps at range ends; slow and fast step periods are parameters.
module setpoint_relay_control #(
    parameter [`CNT_W-1:0] SHOW_CYCLES = `SHOW_MS * `CYC_PER_MS,
    parameter [`CNT_W-1:0] SLOW_CYCLES = `SLOW_STEP_MS * `CYC_PER_MS,
    parameter [`CNT_W-1:0] FAST_CYCLES = `FAST_STEP_MS * `CYC_PER_MS
) (
    // clock and reset
    input  wire                 mclk,
    input  wire                 nrst,
    // apb slave
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [`ADDR_W-1:0]   paddr,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output wire                 pready,
    output wire                 pslverr,
    // display bus pressure
    input  wire                 pressValid,
    input  wire [3:0]           pressDigitHi,
    input  wire [3:0]           pressDigitLo,
    input  wire [`EXP_W-1:0]    pressExpCode,
    // gauge state
    input  wire                 ionGaugeOn,
    input  wire                 degasActive,
    // switches and buttons
    input  wire [1:0]           polarityAbove,
    input  wire [1:0]           relayOneDisablePair,
    input  wire [1:0]           relayTwoDisablePair,
    input  wire [1:0]           overrideOne,
    input  wire [1:0]           overrideTwo,
    input  wire                 chanSel,
    input  wire                 btnUp,
    input  wire                 btnDown,
    // non-volatile store
    input  wire                 nvLoadValid,
    input  wire                 nvLoadChan,
    input  wire [`MAN_W-1:0]    nvLoadMan,
    input  wire [`EXP_W-1:0]    nvLoadExp,
    output reg                  nvWrite,
    output reg                  nvWriteChan,
    output reg  [`MAN_W-1:0]    nvWriteMan,
    output reg  [`EXP_W-1:0]    nvWriteExp,
    // display of setpoint
    output wire                 dispSetpoint,
    output reg  [3:0]           dispDigitHi,
    output reg  [3:0]           dispDigitLo,
    output reg  [`EXP_W-1:0]    dispExpCode,
    // relays and leds
    output wire                 processRelayOne,
    output wire                 processRelayTwo,
    output wire                 ledRelayOne,
    output wire                 ledRelayTwo
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE   = 2'b00;
    localparam [1:0] ST_HELD   = 2'b01;
    localparam [1:0] ST_LINGER = 2'b10;

    reg  [1:0]           state_reg;
    reg  [1:0]           state_next;
    reg  [`CNT_W-1:0]    timer_reg;
    reg  [`CNT_W-1:0]    timer_next;
    reg                  fast_reg;
    reg                  fast_next;
    reg                  adjusted_reg;
    reg                  adjusted_next;
    reg                  editChan_reg;
    reg                  editChan_next;
    reg                  stepNow;
    reg  [`MAN_W-1:0]    spMan_reg [0:1];
    reg  [`EXP_W-1:0]    spExp_reg [0:1];
    reg  [`KEY_W-1:0]    pressKey_reg;
    reg                  pressSeen_reg;
    reg  [1:0]           relay_reg;
    reg  [`MAN_W-1:0]    stepMan;
    reg  [`EXP_W-1:0]    stepExp;
    wire [`MAN_W-1:0]    editMan;
    wire [`EXP_W-1:0]    editExp;
    wire [`MAN_W-1:0]    editHi = editMan / `MAN_TEN;
    wire [`MAN_W-1:0]    editLo = editMan % `MAN_TEN;
    wire [`MAN_W-1:0]    pressMan;
    wire                 showing;
    wire                 anyBtn;
    wire                 apbWrite;
    wire                 apbSetup;
    wire                 mapped;
    wire [1:0]           disabledPair;
    wire [3:0]           overridePos;

    assign showing      = (state_reg != ST_IDLE);
    assign anyBtn       = btnUp | btnDown;
    assign editMan      = spMan_reg[editChan_reg];
    assign editExp      = spExp_reg[editChan_reg];
    assign pressMan     = {pressDigitHi, 3'b000} + {2'b00, pressDigitHi, 1'b0} + {3'b000, pressDigitLo};
    // R7: both switches on disables
    assign disabledPair = {relayTwoDisablePair == `DIS_BOTH_ON, relayOneDisablePair == `DIS_BOTH_ON};
    assign overridePos  = {overrideTwo, overrideOne};

    // ----------------------------------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------------------------------
    assign pready   = 1'b1;
    assign apbWrite = psel & penable & pwrite;
    assign apbSetup = psel & ~penable;
    assign mapped   = (paddr == `ADDR_STATUS) | (paddr == `ADDR_SP_ONE) |
                      (paddr == `ADDR_SP_TWO) | (paddr == `ADDR_PRESSURE);
    assign pslverr  = psel & penable & ~mapped;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (apbSetup) begin
            prdata <= 32'h00000000;
            case (paddr)
                `ADDR_STATUS: begin
                    prdata[`ST_RELAY]      <= relay_reg;
                    prdata[`ST_SHOWING]    <= showing;
                    prdata[`ST_PRESS_SEEN] <= pressSeen_reg;
                    prdata[`ST_DEGAS]      <= degasActive;
                    prdata[`ST_GAUGE_ON]   <= ionGaugeOn;
                    prdata[`ST_ADJUSTED]   <= adjusted_reg;
                end
                `ADDR_SP_ONE: begin
                    prdata[`FLD_MAN] <= spMan_reg[0];
                    prdata[`FLD_EXP] <= spExp_reg[0];
                end
                `ADDR_SP_TWO: begin
                    prdata[`FLD_MAN] <= spMan_reg[1];
                    prdata[`FLD_EXP] <= spExp_reg[1];
                end
                `ADDR_PRESSURE: begin
                    prdata[`FLD_MAN] <= pressKey_reg[`MAN_W-1:0];
                    prdata[`FLD_EXP] <= pressKey_reg[`KEY_W-1:`KEY_W-`EXP_W];
                end
                default: begin
                    prdata <= 32'h00000000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pressure capture
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pressKey_reg  <= `KEY_ZERO;
            pressSeen_reg <= 1'b0;
        // R14: no capture while setpoint shown
        end else if (pressValid && !showing && !degasActive) begin
            // R13: raw display value
            pressKey_reg  <= {pressExpCode, pressMan};
            pressSeen_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // scroll step with clamping
    // ----------------------------------------------------------------
    always @* begin
        stepMan = editMan;
        stepExp = editExp;
        if (btnUp && !btnDown) begin
            // R18: clamp at top of range
            if (editExp == `EXP_MAX && editMan >= `MAN_TOP) begin
                stepMan = `MAN_TOP;
            end else if (editMan == `MAN_MAX) begin
                stepMan = `MAN_MIN;
                stepExp = editExp + `EXP_ONE;
            end else begin
                stepMan = editMan + `MAN_ONE;
            end
        end else if (btnDown && !btnUp) begin
            // R18: clamp at bottom of range
            if (editExp == `EXP_MIN && editMan == `MAN_MIN) begin
                stepMan = `MAN_MIN;
            end else if (editMan == `MAN_MIN) begin
                stepMan = `MAN_MAX;
                stepExp = editExp - `EXP_ONE;
            end else begin
                stepMan = editMan - `MAN_ONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // button and display sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_next    = state_reg;
        timer_next    = timer_reg;
        fast_next     = fast_reg;
        adjusted_next = adjusted_reg;
        editChan_next = editChan_reg;
        stepNow       = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                // R10: channel from selector
                editChan_next = chanSel;
                if (anyBtn) begin
                    // R9: any press shows setpoint
                    state_next    = ST_HELD;
                    timer_next    = `CNT_ZERO;
                    fast_next     = 1'b0;
                    adjusted_next = 1'b0;
                end
            end
            ST_HELD: begin
                if (!anyBtn) begin
                    state_next = ST_LINGER;
                    timer_next = SHOW_CYCLES;
                // R11: slow then fast stepping
                end else if (timer_reg >= (fast_reg ? FAST_CYCLES : SLOW_CYCLES) - `CNT_ONE) begin
                    timer_next    = `CNT_ZERO;
                    stepNow       = 1'b1;
                    adjusted_next = adjusted_reg | (btnUp ^ btnDown);
                    if (stepExp != editExp) begin
                        fast_next = 1'b1;
                    end
                end else begin
                    timer_next = timer_reg + `CNT_ONE;
                end
            end
            ST_LINGER: begin
                if (anyBtn) begin
                    state_next = ST_HELD;
                    timer_next = `CNT_ZERO;
                    fast_next  = 1'b0;
                // R12: two seconds after release
                end else if (timer_reg <= `CNT_ONE) begin
                    state_next = ST_IDLE;
                    timer_next = `CNT_ZERO;
                end else begin
                    timer_next = timer_reg - `CNT_ONE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                timer_next = `CNT_ZERO;
            end
        endcase
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= ST_IDLE;
            timer_reg    <= `CNT_ZERO;
            fast_reg     <= 1'b0;
            adjusted_reg <= 1'b0;
            editChan_reg <= 1'b0;
            nvWrite      <= 1'b0;
            nvWriteChan  <= 1'b0;
            nvWriteMan   <= `SP_RST_MAN;
            nvWriteExp   <= `SP_RST_EXP;
            dispDigitHi  <= 4'h0;
            dispDigitLo  <= 4'h0;
            dispExpCode  <= `EXP_MIN;
        end else begin
            state_reg    <= state_next;
            timer_reg    <= timer_next;
            fast_reg     <= fast_next;
            adjusted_reg <= adjusted_next;
            editChan_reg <= editChan_next;
            // R12: commit edited setpoint to storage
            nvWrite      <= (state_reg == ST_LINGER) && (state_next == ST_IDLE) && adjusted_reg;
            nvWriteChan  <= editChan_reg;
            nvWriteMan   <= editMan;
            nvWriteExp   <= editExp;
            dispDigitHi  <= editHi[3:0];
            dispDigitLo  <= editLo[3:0];
            dispExpCode  <= editExp;
        end
    end

    assign dispSetpoint = showing;

    // ----------------------------------------------------------------
    // per-channel setpoint store and relay decision
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : chan
            wire [`MAN_W-1:0] spMan;
            wire [`EXP_W-1:0] spExp;
            wire [`MAN_W-1:0] hyst;
            wire [`MAN_W:0]   highSum;
            wire [`MAN_W-1:0] highCarry;
            wire [`KEY_W-1:0] lowKey;
            wire [`KEY_W-1:0] highKey;
            wire              atLow;
            wire              atHigh;
            wire              spAddr;
            reg               relay_next;

            assign spMan  = spMan_reg[ch];
            assign spExp  = spExp_reg[ch];
            assign spAddr = (paddr == (ch == 0 ? `ADDR_SP_ONE : `ADDR_SP_TWO));
            // R4: one-digit hysteresis, rounded
            assign hyst = spMan / `MAN_TEN + ((spMan % `MAN_TEN) >= `MAN_HALF ? `MAN_ONE : 7'h00);
            // R3: release at setpoint plus hysteresis plus one digit
            assign highSum   = {1'b0, spMan} + {1'b0, hyst} + {1'b0, `MAN_ONE};
            assign highCarry = highSum[`MAN_W-1:0] / `MAN_TEN + (highSum[`MAN_W] ? 7'h0C : 7'h00);
            assign highKey   = (highSum > {1'b0, `MAN_MAX}) ? {spExp + `EXP_ONE, highCarry}
                                                            : {spExp, highSum[`MAN_W-1:0]};
            // R3: activate one digit below setpoint
            assign lowKey = (spMan != `MAN_MIN) ? {spExp, spMan - `MAN_ONE} :
                            (spExp == `EXP_MIN) ? `KEY_ZERO : {spExp - `EXP_ONE, `MAN_MAX};
            assign atLow  = pressSeen_reg && (pressKey_reg <= lowKey);
            assign atHigh = pressSeen_reg && (pressKey_reg >= highKey);

            // R16: working copies of setpoints
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    spMan_reg[ch] <= `SP_RST_MAN;
                    spExp_reg[ch] <= `SP_RST_EXP;
                end else if (apbWrite && spAddr) begin
                    spMan_reg[ch] <= pwdata[`FLD_MAN];
                    spExp_reg[ch] <= pwdata[`FLD_EXP];
                end else if (nvLoadValid && nvLoadChan == ch) begin
                    spMan_reg[ch] <= nvLoadMan;
                    spExp_reg[ch] <= nvLoadExp;
                // R11: step the edited channel
                end else if (stepNow && editChan_reg == ch) begin
                    spMan_reg[ch] <= stepMan;
                    spExp_reg[ch] <= stepExp;
                end
            end

            always @* begin
                relay_next = relay_reg[ch];
                // R17: fixed priority chain
                if (disabledPair[ch]) begin
                    relay_next = 1'b0;
                // R5: gauge off releases relay
                end else if (!ionGaugeOn) begin
                    relay_next = 1'b0;
                // R6: hold during degas
                end else if (degasActive) begin
                    relay_next = relay_reg[ch];
                // R8: manual override
                end else if (overridePos[2*ch+1 -: 2] == `OVR_FORCE_ON) begin
                    relay_next = 1'b1;
                end else if (overridePos[2*ch+1 -: 2] == `OVR_FORCE_OFF) begin
                    relay_next = 1'b0;
                // R2: polarity selects sense
                end else if (polarityAbove[ch]) begin
                    if (atHigh) begin
                        relay_next = 1'b1;
                    end else if (atLow) begin
                        relay_next = 1'b0;
                    end
                end else begin
                    if (atLow) begin
                        relay_next = 1'b1;
                    end else if (atHigh) begin
                        relay_next = 1'b0;
                    end
                end
            end

            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    relay_reg[ch] <= 1'b0;
                end else begin
                    relay_reg[ch] <= relay_next;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // relay and led outputs
    // ----------------------------------------------------------------
    assign processRelayOne = relay_reg[0];
    assign processRelayTwo = relay_reg[1];
    // R15: leds follow actual relay state
    assign ledRelayOne     = relay_reg[0];
    assign ledRelayTwo     = relay_reg[1];

endmodule
`default_nettype wire

//--- dv/display_bus_model.sv
// display bus model sending pressure words
`timescale 1ns/1ps
`default_nettype none
module display_bus_model (
    // clock
    input  wire logic       mclk,
    // pressure word
    output var  logic       pressValid,
    output var  logic [3:0] pressDigitHi,
    output var  logic [3:0] pressDigitLo,
    output var  logic [4:0] pressExpCode
);
initial begin
    pressValid = 1'b0;
    pressDigitHi = 4'hF;
    pressDigitLo = 4'hF;
    pressExpCode = 5'h1F;
end
// one word per pulse, lines inverted once released
task send(input logic [3:0] hi, input logic [3:0] lo, input logic [4:0] ex);
    @(posedge mclk);
    pressValid <= 1'b1;
    pressDigitHi <= hi;
    pressDigitLo <= lo;
    pressExpCode <= ex;
    @(posedge mclk);
    pressValid <= 1'b0;
    pressDigitHi <= ~hi;
    pressDigitLo <= ~lo;
    pressExpCode <= ~ex;
endtask
endmodule
`default_nettype wire

//--- dv/setpoint_relay_chk.sv
// assertion checker for the setpoint relay controller
`timescale 1ns/1ps
`default_nettype none
module setpoint_relay_chk (
    // clock and reset
    input wire logic       mclk,
    input wire logic       nrst,
    // controls
    input wire logic       ionGaugeOn,
    input wire logic       degasActive,
    input wire logic [1:0] relayOneDisablePair,
    input wire logic [1:0] relayTwoDisablePair,
    input wire logic [1:0] overrideOne,
    input wire logic [1:0] overrideTwo,
    input wire logic       btnUp,
    input wire logic       btnDown,
    // results
    input wire logic       nvWrite,
    input wire logic       dispSetpoint,
    input wire logic       processRelayOne,
    input wire logic       processRelayTwo,
    input wire logic       ledRelayOne,
    input wire logic       ledRelayTwo
);
default clocking @(posedge mclk); endclocking
default disable iff (!nrst);
// ----------------------------------------
// relay checks
// ----------------------------------------
led_state_a: assert property (ledRelayOne == processRelayOne && ledRelayTwo == processRelayTwo)
    else $error("led differs from relay");
disable_off_a: assert property (relayTwoDisablePair == 2'b11 |=> !processRelayTwo)
    else $error("disabled relay active");
gauge_off_a: assert property (!ionGaugeOn |=> !processRelayOne && !processRelayTwo)
    else $error("relay active with gauge off");
degas_hold_a: assert property (degasActive && ionGaugeOn && relayTwoDisablePair != 2'b11 |=> $stable(processRelayTwo))
    else $error("relay moved in degas");
force_on_a: assert property (ionGaugeOn && !degasActive && relayTwoDisablePair != 2'b11 && overrideTwo == 2'b01
    |=> processRelayTwo)
    else $error("override right not active");
force_off_a: assert property (overrideOne == 2'b10 && !degasActive |=> !processRelayOne)
    else $error("override left not inactive");
// ----------------------------------------
// display and storage checks
// ----------------------------------------
show_press_a: assert property (btnUp || btnDown |=> dispSetpoint)
    else $error("setpoint not shown");
store_pulse_a: assert property (nvWrite |=> !nvWrite)
    else $error("store pulse too long");
store_idle_a: assert property (nvWrite |-> !dispSetpoint)
    else $error("store while showing");
cover property ($rose(processRelayOne));
cover property (nvWrite);
cover property ($fell(dispSetpoint));
endmodule
bind setpoint_relay_control setpoint_relay_chk chk (.mclk, .nrst, .ionGaugeOn, .degasActive,
    .relayOneDisablePair, .relayTwoDisablePair, .overrideOne, .overrideTwo, .btnUp, .btnDown,
    .nvWrite, .dispSetpoint, .processRelayOne, .processRelayTwo, .ledRelayOne, .ledRelayTwo);
`default_nettype wire

//--- dv/tb_top.sv
// self-checking testbench for the setpoint relay controller
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_relay_regs.vh"
module tb_top;
// ----------------------------------------
// signals
// ----------------------------------------
logic        mclk, nrst, psel, penable, pwrite, ionGaugeOn, degasActive, chanSel, btnUp, btnDown, er, nvLoadValid;
logic [11:0] paddr;
logic [31:0] pwdata, rd;
logic [1:0]  polarityAbove, relayOneDisablePair, relayTwoDisablePair, overrideOne, overrideTwo;
wire         pready, pslverr, pressValid, nvWrite, nvWriteChan, dispSetpoint;
wire         processRelayOne, processRelayTwo, ledRelayOne, ledRelayTwo;
wire [31:0]  prdata;
wire [3:0]   pressDigitHi, pressDigitLo, dispDigitHi, dispDigitLo;
wire [4:0]   pressExpCode, nvWriteExp, dispExpCode;
wire [6:0]   nvWriteMan;
int          n_fail, n_tests, nvCount;
localparam logic [15:0] HYST [8] = '{16'h0652, 16'h0623, 16'h0693, 16'h0702,
                                     16'h0732, 16'h0740, 16'h3743, 16'h3651};
setpoint_relay_control #(.SHOW_CYCLES(28'h14), .SLOW_CYCLES(28'h8), .FAST_CYCLES(28'h2)) uut (
    .mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pressValid, .pressDigitHi, .pressDigitLo, .pressExpCode, .ionGaugeOn, .degasActive,
    .polarityAbove, .relayOneDisablePair, .relayTwoDisablePair, .overrideOne, .overrideTwo,
    .chanSel, .btnUp, .btnDown, .nvLoadValid, .nvLoadChan(chanSel), .nvLoadMan(7'h0A),
    .nvLoadExp(5'h06), .nvWrite, .nvWriteChan, .nvWriteMan, .nvWriteExp, .dispSetpoint,
    .dispDigitHi, .dispDigitLo, .dispExpCode, .processRelayOne, .processRelayTwo,
    .ledRelayOne, .ledRelayTwo);
display_bus_model bus (.mclk, .pressValid, .pressDigitHi, .pressDigitLo, .pressExpCode);
initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
end
always @(posedge mclk) if (nvWrite === 1'b1) nvCount++;
// ----------------------------------------
// helpers
// ----------------------------------------
task tick(input int n);
    repeat (n) @(posedge mclk);
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
        n_fail++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
endtask
task rel(input logic a, input logic b);
    tick(3);
    chk({30'h0, processRelayTwo, processRelayOne}, {30'h0, b, a});
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
        @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task idle;
    while (dispSetpoint !== 1'b0) tick(1);
endtask
task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_regs;
    apb(1'b0, `ADDR_SP_ONE, 32'h0);
    chk(rd, 32'h0000060A);
    apb(1'b0, 12'h010, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, `ADDR_SP_ONE, 32'h0000063F);
    apb(1'b1, `ADDR_SP_TWO, 32'h00000642);
    apb(1'b0, `ADDR_SP_TWO, 32'h0);
    chk(rd, 32'h00000642);
endtask
task t_hyst;
    for (int i = 0; i < 8; i++) begin
        polarityAbove <= HYST[i][13:12];
        bus.send(HYST[i][11:8], HYST[i][7:4], 5'h06);
        rel(HYST[i][0], HYST[i][1]);
    end
endtask
task t_hold;
    degasActive <= 1'b1;
    bus.send(4'h7, 4'h4, 5'h06);
    rel(1'b1, 1'b0);
    degasActive <= 1'b0;
    rel(1'b1, 1'b0);
    overrideTwo <= 2'b01;
    rel(1'b1, 1'b1);
    relayTwoDisablePair <= 2'b11;
    rel(1'b1, 1'b0);
    overrideOne <= 2'b10;
    rel(1'b0, 1'b0);
    overrideOne <= 2'b00;
    overrideTwo <= 2'b00;
    relayTwoDisablePair <= 2'b00;
    bus.send(4'h7, 4'h4, 5'h06);
    rel(1'b1, 1'b1);
    ionGaugeOn <= 1'b0;
    rel(1'b0, 1'b0);
    ionGaugeOn <= 1'b1;
    rel(1'b1, 1'b1);
endtask
task t_btn;
    chanSel <= 1'b1;
    btnDown <= 1'b1;
    tick(1);
    btnDown <= 1'b0;
    tick(3);
    chk({19'h0, dispExpCode, dispDigitHi, dispDigitLo}, {19'h0, 5'h06, 8'h66});
    bus.send(4'h6, 4'h2, 5'h06);
    idle;
    chk(nvCount, 32'h0);
    rel(1'b1, 1'b1);
    btnUp <= 1'b1;
    tick(12);
    btnUp <= 1'b0;
    while (nvWrite !== 1'b1) tick(1);
    chk({19'h0, nvWriteChan, nvWriteExp, nvWriteMan}, {19'h0, 1'b1, 5'h06, 7'h43});
    apb(1'b0, `ADDR_SP_TWO, 32'h0);
    chk(rd, 32'h00000643);
endtask
task t_scroll;
    chanSel <= 1'b0;
    apb(1'b1, `ADDR_SP_ONE, 32'h00000662);
    btnUp <= 1'b1;
    tick(26);
    btnUp <= 1'b0;
    apb(1'b0, `ADDR_SP_ONE, 32'h0);
    chk(rd, 32'h0000070E);
    idle;
    apb(1'b1, `ADDR_SP_ONE, 32'h0000115A);
    btnUp <= 1'b1;
    tick(12);
    btnUp <= 1'b0;
    apb(1'b0, `ADDR_SP_ONE, 32'h0);
    chk(rd, 32'h0000115A);
    nvLoadValid <= 1'b1;
    tick(1);
    nvLoadValid <= 1'b0;
    apb(1'b0, `ADDR_SP_ONE, 32'h0);
    chk(rd, 32'h0000060A);
endtask
// ----------------------------------------
// main sequence and watchdog
// ----------------------------------------
initial begin
    {nrst, psel, penable, pwrite, degasActive, chanSel, btnUp, btnDown, nvLoadValid} = 9'h000;
    ionGaugeOn = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    {polarityAbove, relayOneDisablePair, relayTwoDisablePair, overrideOne, overrideTwo} = 10'h000;
    tick(5);
    nrst <= 1'b1;
    t_regs;
    t_hyst;
    t_hold;
    t_btn;
    t_scroll;
    close_out;
end
initial begin
    #100000;
    n_fail++;
    close_out;
end
endmodule
`default_nettype wire
